// ---- include/sqp_pkg.sv ----
// shared constants of the quad serial port block
`default_nettype none
package sqp_pkg;
    // timing
    localparam int unsigned CLK_HZ    = 100_000_000;
    localparam int unsigned REF_HZ    = 1_843_200;
    localparam int unsigned PRESC_CYC = CLK_HZ / REF_HZ;
    localparam int unsigned PRESC_W   = $clog2(PRESC_CYC);
    // port windows, as word indexes
    localparam logic [9:0] BASE_P1 = 10'h3f8;
    localparam logic [9:0] BASE_P2 = 10'h2f8;
    localparam logic [9:0] BASE_P3 = 10'h3e8;
    localparam logic [9:0] BASE_P4 = 10'h2e8;
    // block-wide registers
    localparam logic [9:0] CFG_IDX = 10'h100;
    localparam logic [9:0] STS_IDX = 10'h101;
    localparam logic [9:0] MSK_IDX = 10'h102;
    localparam logic [9:0] PCI_IDX = 10'h103;
    // offsets inside a port window
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_DIVH = 3'h1;
    localparam logic [2:0] OFS_LCR  = 3'h3;
    localparam logic [2:0] OFS_MCR  = 3'h4;
    localparam logic [2:0] OFS_LSR  = 3'h5;
    localparam logic [2:0] OFS_MSR  = 3'h6;
    localparam logic [2:0] OFS_SCR  = 3'h7;
    // field positions
    localparam int LCR_STOP    = 2;
    localparam int LCR_DLAB    = 7;
    localparam int MCR_DTR     = 0;
    localparam int MCR_RTS     = 1;
    localparam int CFG_DIS_LSB = 0;
    localparam int CFG_RT_LSB  = 4;
    // values after reset
    localparam logic [7:0]  LCR_RST = 8'h03;
    localparam logic [15:0] DIV_RST = 16'h000c;
    localparam logic [11:0] CFG_RST = 12'h110;
endpackage
`default_nettype wire

// ---- verilog/serial_port_engine.sv ----
// one serial port: 16x divider, transmitter and receiver
`default_nettype none
module serial_port_engine
    import sqp_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // clock and control
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             tick_in,
    // line format
    input  wire logic [DIV_W-1:0] div_in,
    input  wire logic [1:0]       len_in,
    input  wire logic             stop2_in,
    // transmit side
    input  wire logic             tx_go_in,
    input  wire logic [7:0]       tx_byte_in,
    output logic                  tx_idle_out,
    output logic                  txd_out,
    // receive side
    input  wire logic             rxd_in,
    output logic [7:0]            rx_byte_out,
    output logic                  rx_stb_out
);
    if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div
        $error("DIV_W must lie in 2..16");
    end

    logic [DIV_W-1:0] div_cnt_r;
    logic             os;
    logic [3:0]       nb;
    logic [8:0]       tx_end;
    logic [8:0]       tx_t_r;
    logic [8:0]       rx_t_r;
    logic [7:0]       tx_sh_r;
    logic [7:0]       rx_sh_r;
    logic             tx_busy_r;
    logic             rx_busy_r;
    logic             rx_s1_r;
    logic             rx_s2_r;

    // a zero divisor behaves as one
    assign os = tick_in && (div_cnt_r + 1'b1 >= div_in);
    assign nb = 4'h5 + {2'b00, len_in};
    // [R5] stop of 16, 24 or 32 oversample ticks
    assign tx_end = {1'b0, nb, 4'h0} + 9'h010
                  + (stop2_in ? (len_in == 2'b00 ? 9'h018 : 9'h020) : 9'h010);
    assign tx_idle_out = !tx_busy_r;

    // oversample divider
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div_cnt_r <= '0;
        end else if (ce_in && tick_in) begin
            div_cnt_r <= os ? '0 : div_cnt_r + 1'b1;
        end
    end

    // [R5] transmit frame, five to eight bits
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_busy_r <= 1'b0;
            tx_t_r    <= '0;
            tx_sh_r   <= '0;
            txd_out   <= 1'b1;
        end else if (ce_in) begin
            if (!tx_busy_r && tx_go_in) begin
                tx_busy_r <= 1'b1;
                tx_t_r    <= '0;
                tx_sh_r   <= tx_byte_in;
            end else if (tx_busy_r && os) begin
                tx_t_r <= tx_t_r + 9'h001;
                if (tx_t_r + 9'h001 == tx_end) begin
                    tx_busy_r <= 1'b0;
                end
            end
            if (!tx_busy_r || tx_t_r[8:4] > {1'b0, nb}) begin
                txd_out <= 1'b1;
            end else if (tx_t_r[8:4] == 5'h00) begin
                txd_out <= 1'b0;
            end else begin
                txd_out <= tx_sh_r[3'(tx_t_r[8:4] - 5'h01)];
            end
        end
    end

    // [R5] receive, sampled mid-bit; framing errors are not flagged
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_s1_r     <= 1'b1;
            rx_s2_r     <= 1'b1;
            rx_busy_r   <= 1'b0;
            rx_t_r      <= '0;
            rx_sh_r     <= '0;
            rx_byte_out <= '0;
            rx_stb_out  <= 1'b0;
        end else if (ce_in) begin
            rx_s1_r    <= rxd_in;
            rx_s2_r    <= rx_s1_r;
            rx_stb_out <= 1'b0;
            if (!rx_busy_r && os && !rx_s2_r) begin
                rx_busy_r <= 1'b1;
                rx_t_r    <= '0;
            end else if (rx_busy_r && os) begin
                rx_t_r <= rx_t_r + 9'h001;
                if (rx_t_r[3:0] == 4'h7) begin
                    if (rx_t_r[8:4] == 5'h00 && rx_s2_r) begin
                        rx_busy_r <= 1'b0;  // glitch, not a start bit
                    end else if (rx_t_r[8:4] <= {1'b0, nb}) begin
                        rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
                    end else begin
                        rx_busy_r   <= 1'b0;
                        rx_byte_out <= rx_sh_r >> (4'h8 - nb);
                        rx_stb_out  <= 1'b1;
                    end
                end
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    start_bit_low_a: assert property ((tx_go_in && !tx_busy_r && ce_in) ##1 ce_in
        |-> ##1 !txd_out) else $error("start bit not driven low"); // [R5]
    cover property (rx_stb_out);
endmodule
`default_nettype wire

// ---- verilog/quad_serial_port_decode_irq.sv ----
// four serial ports with window decode and interrupt line routing
//
// Chosen here: the register offsets and register access over Wishbone.
`default_nettype none
// Notes on behaviour
// [R1] Port windows of eight bytes sit at 3f8, 2f8, 3e8 and 2e8.
// [R2] A disabled port answers no access and lets go of its line.
// [R3] Ports one and two carry carrier detect, set ready, ring and terminal ready.
// [R4] Ports three and four carry only data, request and clear to send.
// [R5] Every port takes a divisor, five to eight bits and 1, 1.5 or 2 stops.
// [R6] Ports three and four route to any of four lines, one and two to the low two.
// [R7] A line owned by the PCI side is never driven by a port.
// [R8] Firmware keeps ports off lines that were given to the PCI side.
// [R9] Firmware numbers the enabled ports upward, skipping disabled ones.
// [R10] The low three address bits pick the register of an enabled port.
module quad_serial_port_decode_irq
    import sqp_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // clock, reset, enable
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        CE_IN,
    // wishbone slave
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [11:0] WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    output logic             WB_ERR_OUT,
    // serial lines
    input  wire logic [3:0]  RXD_IN,
    input  wire logic [3:0]  CTS_IN,
    input  wire logic [1:0]  DCD_IN,
    input  wire logic [1:0]  DSR_IN,
    input  wire logic [1:0]  RI_IN,
    output logic      [3:0]  TXD_OUT,
    output logic      [3:0]  RTS_OUT,
    output logic      [1:0]  DTR_OUT,
    // interrupt lines 3, 4, 10, 12 and summary
    output logic      [3:0]  IRQ_LINE_OUT,
    output logic      [3:0]  IRQ_LINE_OE_OUT,
    output logic             INT_OUT
);
    if (DIV_W != 16) begin : g_bad_div
        $error("divisor latch is two bytes wide");
    end

    logic [9:0]  idx;
    logic [2:0]  ofs;
    logic        req;
    logic        valid;
    logic        wr;
    logic        rd;
    logic        lane0;
    logic [3:0]  hit;
    logic [3:0]  dis;
    logic        hit_cfg;
    logic        hit_sts;
    logic        hit_msk;
    logic        hit_pci;
    logic [15:0] wmask;
    logic [11:0] cfg_r;
    logic [7:0]  sts_r;
    logic [7:0]  msk_r;
    logic [3:0]  pci_r;
    logic [7:0]  ev;
    logic [7:0]  lcr_r [4];
    logic [7:0]  mcr_r [4];
    logic [7:0]  scr_r [4];
    logic [7:0]  rxb_r [4];
    logic [15:0] div_r [4];
    logic [7:0]  rx_byte [4];
    logic [3:0]  rdy_r;
    logic [3:0]  ovr_r;
    logic [3:0]  tx_idle;
    logic [3:0]  txi_q_r;
    logic [3:0]  rx_stb;
    logic [3:0]  tx_go;
    logic [3:0]  pop;
    logic [9:0]  mdm_s1_r;
    logic [9:0]  mdm_s2_r;
    logic [PRESC_W-1:0] presc_r;
    logic        tick_r;
    logic [31:0] rdat;
    logic [3:0]  lvl;
    logic [3:0]  oe;

    function automatic logic [9:0] port_base(input int p);
        case (p)
            0: port_base = BASE_P1;
            1: port_base = BASE_P2;
            2: port_base = BASE_P3;
            default: port_base = BASE_P4;
        endcase
    endfunction

    // line code 0..3 is IRQ3, IRQ4, IRQ10, IRQ12
    function automatic logic [1:0] eff_route(input int p, input logic [11:0] cfg);
        logic [1:0] r;
        r = cfg[CFG_RT_LSB + 2*p +: 2];
        // [R6] low ports keep only the select of line 3 or 4
        eff_route = (p < 2) ? {1'b0, r[0]} : r;
    endfunction

    // bus decode
    always_comb begin
        logic [9:0] b;
        b       = '0;
        idx     = WB_ADR_IN[11:2];
        ofs     = idx[2:0];
        req     = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
        hit_cfg = idx == CFG_IDX;
        hit_sts = idx == STS_IDX;
        hit_msk = idx == MSK_IDX;
        hit_pci = idx == PCI_IDX;
        for (int p = 0; p < 4; p++) begin
            b      = port_base(p);
            dis[p] = cfg_r[CFG_DIS_LSB + p];
            // [R1] [R2] [R10] window hit only while enabled
            hit[p] = !dis[p] && idx[9:3] == b[9:3];
        end
        valid = |hit || hit_cfg || hit_sts || hit_msk || hit_pci;
        wr    = req && valid && WB_WE_IN;
        rd    = req && valid && !WB_WE_IN;
        lane0 = wr && WB_SEL_IN[0];
        wmask = {{8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
    end

    // per-port strobes and interrupt events
    always_comb begin
        logic dl;
        dl = 1'b0;
        for (int p = 0; p < 4; p++) begin
            dl = lcr_r[p][LCR_DLAB];
            tx_go[p] = lane0 && hit[p] && ofs == OFS_DATA && !dl;
            pop[p]   = rd && hit[p] && ofs == OFS_DATA && !dl;
            ev[2*p]   = rx_stb[p];
            ev[2*p+1] = tx_idle[p] && !txi_q_r[p];
        end
    end

    // read data
    always_comb begin
        logic dl;
        dl   = 1'b0;
        rdat = '0;
        if (hit_cfg) begin
            rdat[11:0] = cfg_r;
        end else if (hit_sts) begin
            rdat[7:0] = sts_r;
        end else if (hit_msk) begin
            rdat[7:0] = msk_r;
        end else if (hit_pci) begin
            rdat[3:0] = pci_r;
        end else begin
            for (int p = 0; p < 4; p++) begin
                dl = lcr_r[p][LCR_DLAB];
                if (hit[p]) begin
                    // [R10] register picked by the low bits
                    case (ofs)
                        OFS_DATA: rdat[7:0] = dl ? div_r[p][7:0] : rxb_r[p];
                        OFS_DIVH: rdat[7:0] = dl ? div_r[p][15:8] : 8'h00;
                        OFS_LCR:  rdat[7:0] = lcr_r[p];
                        OFS_MCR:  rdat[7:0] = mcr_r[p];
                        OFS_LSR:  rdat[7:0] = {1'b0, tx_idle[p], tx_idle[p],
                                               3'b000, ovr_r[p], rdy_r[p]};
                        OFS_MSR: begin
                            rdat[4] = mdm_s2_r[p];
                            // [R3] [R4] set ready, ring and carrier detect on the low ports only
                            if (p < 2) begin
                                rdat[5] = mdm_s2_r[4+p];
                                rdat[6] = mdm_s2_r[6+p];
                                rdat[7] = mdm_s2_r[8+p];
                            end
                        end
                        OFS_SCR:  rdat[7:0] = scr_r[p];
                        default:  rdat[7:0] = 8'h00;
                    endcase
                end
            end
        end
    end

    // bus answer, one cycle after the request
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_ERR_OUT <= 1'b0;
            WB_DAT_OUT <= '0;
        end else if (CE_IN) begin
            WB_ACK_OUT <= req && valid;
            // [R2] unmapped and disabled windows end in error
            WB_ERR_OUT <= req && !valid;
            if (req) begin
                WB_DAT_OUT <= rdat;
            end
        end
    end

    // block configuration, byte lanes honoured
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            cfg_r <= CFG_RST;
            msk_r <= '0;
            pci_r <= '0;
        end else if (CE_IN) begin
            if (wr && hit_cfg) begin
                cfg_r <= (cfg_r & ~wmask[11:0]) | (WB_DAT_IN[11:0] & wmask[11:0]);
            end
            if (lane0 && hit_msk) begin
                msk_r <= WB_DAT_IN[7:0];
            end
            if (lane0 && hit_pci) begin
                pci_r <= WB_DAT_IN[3:0];
            end
        end
    end

    // sticky status: a new event beats a same-cycle clear
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            sts_r <= '0;
        end else if (CE_IN) begin
            sts_r <= (sts_r & ~(lane0 && hit_sts ? WB_DAT_IN[7:0] : 8'h00)) | ev;
        end
    end

    // per-port line and modem control registers
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            for (int p = 0; p < 4; p++) begin
                lcr_r[p] <= LCR_RST;
                mcr_r[p] <= '0;
                scr_r[p] <= '0;
                div_r[p] <= DIV_RST;
            end
        end else if (CE_IN) begin
            for (int p = 0; p < 4; p++) begin
                if (lane0 && hit[p]) begin
                    case (ofs)
                        OFS_DATA: if (lcr_r[p][LCR_DLAB]) div_r[p][7:0] <= WB_DAT_IN[7:0];
                        OFS_DIVH: if (lcr_r[p][LCR_DLAB]) div_r[p][15:8] <= WB_DAT_IN[7:0];
                        OFS_LCR:  lcr_r[p] <= WB_DAT_IN[7:0];
                        // [R4] no terminal ready bit on the high ports
                        OFS_MCR:  mcr_r[p] <= p < 2 ? WB_DAT_IN[7:0]
                                                    : WB_DAT_IN[7:0] & 8'hfe;
                        OFS_SCR:  scr_r[p] <= WB_DAT_IN[7:0];
                        default:  ;
                    endcase
                end
            end
        end
    end

    // received bytes; overrun when the last one was never read
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            rdy_r <= '0;
            ovr_r <= '0;
            for (int p = 0; p < 4; p++) begin
                rxb_r[p] <= '0;
            end
        end else if (CE_IN) begin
            for (int p = 0; p < 4; p++) begin
                if (rx_stb[p]) begin
                    rxb_r[p] <= rx_byte[p];
                    rdy_r[p] <= 1'b1;
                    ovr_r[p] <= ovr_r[p] | (rdy_r[p] && !pop[p]);
                end else begin
                    if (pop[p]) begin
                        rdy_r[p] <= 1'b0;
                    end
                    if (rd && hit[p] && ofs == OFS_LSR) begin
                        ovr_r[p] <= 1'b0;
                    end
                end
            end
        end
    end

    // pin synchronisers, divider reference, idle history
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            mdm_s1_r <= '0;
            mdm_s2_r <= '0;
            presc_r  <= '0;
            tick_r   <= 1'b0;
            txi_q_r  <= 4'hf;
        end else if (CE_IN) begin
            mdm_s1_r <= {DCD_IN, RI_IN, DSR_IN, CTS_IN};
            mdm_s2_r <= mdm_s1_r;
            tick_r   <= presc_r == PRESC_W'(PRESC_CYC - 1);
            presc_r  <= presc_r == PRESC_W'(PRESC_CYC - 1) ? '0 : presc_r + 1'b1;
            txi_q_r  <= tx_idle;
        end
    end

    // [R3] [R4] handshake outputs straight from the control flops
    assign RTS_OUT = {mcr_r[3][MCR_RTS], mcr_r[2][MCR_RTS],
                      mcr_r[1][MCR_RTS], mcr_r[0][MCR_RTS]};
    assign DTR_OUT = {mcr_r[1][MCR_DTR], mcr_r[0][MCR_DTR]};

    // line owners: enabled ports routed there, unless the PCI side holds it
    always_comb begin
        for (int l = 0; l < 4; l++) begin
            lvl[l] = 1'b0;
            oe[l]  = 1'b0;
            for (int p = 0; p < 4; p++) begin
                // [R2] [R6] only enabled ports claim a line
                if (!dis[p] && eff_route(p, cfg_r) == 2'(l)) begin
                    oe[l]  = 1'b1;
                    lvl[l] = lvl[l] | (|(sts_r[2*p +: 2] & msk_r[2*p +: 2]));
                end
            end
            // [R7] a PCI-owned line stays undriven
            oe[l] = oe[l] && !pci_r[l];
        end
    end

    // interrupt outputs
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            IRQ_LINE_OUT    <= '0;
            IRQ_LINE_OE_OUT <= '0;
            INT_OUT         <= 1'b0;
        end else if (CE_IN) begin
            IRQ_LINE_OUT    <= lvl & oe;
            IRQ_LINE_OE_OUT <= oe;
            INT_OUT         <= |(sts_r & msk_r);
        end
    end

    // [R5] one engine per port
    for (genvar g = 0; g < 4; g++) begin : g_port
        serial_port_engine #(.DIV_W(DIV_W)) u_eng (
            .clk_in      (CORE_CLK_IN),
            .rst_in      (RST_IN),
            .ce_in       (CE_IN),
            .tick_in     (tick_r),
            .div_in      (div_r[g]),
            .len_in      (lcr_r[g][1:0]),
            .stop2_in    (lcr_r[g][LCR_STOP]),
            .tx_go_in    (tx_go[g]),
            .tx_byte_in  (WB_DAT_IN[7:0]),
            .tx_idle_out (tx_idle[g]),
            .txd_out     (TXD_OUT[g]),
            .rxd_in      (RXD_IN[g]),
            .rx_byte_out (rx_byte[g]),
            .rx_stb_out  (rx_stb[g])
        );
    end

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    port_one_ack_a: assert property (CE_IN && req && !dis[0] && idx == BASE_P1 // [R1]
        |=> WB_ACK_OUT) else $error("port one window not answered");
    port_off_err_a: assert property (CE_IN && req && dis[2] // [R2]
        && idx[9:3] == BASE_P3[9:3] |=> WB_ERR_OUT && !WB_ACK_OUT)
        else $error("disabled port still answers");
    lines_released_a: assert property (CE_IN && &dis // [R2]
        |=> IRQ_LINE_OE_OUT == 4'h0) else $error("disabled ports hold a line");
    dtr_follows_a: assert property (CE_IN && lane0 && hit[0] && ofs == OFS_MCR // [R3]
        |=> DTR_OUT[0] == $past(WB_DAT_IN[MCR_DTR])) else $error("terminal ready stale");
    msr_short_a: assert property (CE_IN && rd && (hit[2] || hit[3]) && ofs == OFS_MSR // [R4]
        |=> WB_DAT_OUT[7:5] == 3'b000) else $error("high port shows modem lines");
    high_lines_free_a: assert property (CE_IN && dis[2] && dis[3] // [R6]
        |=> IRQ_LINE_OE_OUT[3:2] == 2'b00) else $error("low port on high line");
    pci_line_free_a: assert property (CE_IN // [R7]
        |=> (IRQ_LINE_OE_OUT & $past(pci_r)) == 4'h0) else $error("PCI line driven");
    scr_select_a: assert property (CE_IN && rd && hit[1] && ofs == OFS_SCR // [R10]
        |=> WB_DAT_OUT[7:0] == $past(scr_r[1])) else $error("wrong register read");
    rx_sticky_a: assert property (CE_IN && rx_stb[0] |=> sts_r[0] ##1 CE_IN |=> INT_OUT
        || !$past(msk_r[0])) else $error("receive event lost");

    cover property (WB_ACK_OUT && $past(tx_go[0]));
    cover property (rx_stb[3] && !dis[3]);
    cover property (INT_OUT && IRQ_LINE_OUT[2]);
    cover property (WB_ERR_OUT);
endmodule
`default_nettype wire

// ---- sim/serial_peer_model.sv ----
// far-side serial peer: data and modem lines into the ports
`default_nettype none
module serial_peer_model (
    // clock and lines
    input  wire logic       clk_in,
    output logic      [3:0] rxd_out,
    output logic      [3:0] cts_out,
    output logic      [1:0] dcd_out,
    output logic      [1:0] dsr_out,
    output logic      [1:0] ri_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // static modem levels, distinct per port
    initial begin
        rxd_out = 4'hf;
        cts_out = 4'h4;
        dcd_out = 2'h1;
        dsr_out = 2'h2;
        ri_out  = 2'h0;
    end
    // start, eight data lsb first, stop; line idles high after
    task automatic send(input int p, input logic [7:0] b, input int bc);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int k = 0; k < 10; k++) begin
            @(posedge clk_in);
            rxd_out[p] <= f[k];
            repeat (bc - 1) @(posedge clk_in);
        end
    endtask
endmodule
`default_nettype wire

// ---- sim/quad_serial_port_decode_irq_tb.sv ----
// bench for the quad serial port block
`default_nettype none
module quad_serial_port_decode_irq_tb
    import sqp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [9:0] i; logic [7:0] d, m, x; logic e;} row_t;
    localparam int BIT_CYC = 16 * PRESC_CYC;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we  = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0, dout, q;
    logic        ack, err, e, intr;
    logic [3:0]  rxd, cts, txd, rts, irq, oe;
    logic [1:0]  dcd, dsr, ri, dtr;
    int          n_fail = 0, comparisons = 0, n;
    int          desig[4];
    logic [9:0]  bases[4] = '{BASE_P1, BASE_P2, BASE_P3, BASE_P4};
    // plain accesses: window edges, reset values, modem status
    row_t rows[10] = '{
        '{0, BASE_P1 + OFS_LCR, 0, 8'hff, LCR_RST, 0},
        '{1, BASE_P4 + OFS_SCR, 8'ha5, 0, 0, 0},
        '{0, BASE_P4 + OFS_SCR, 0, 8'hff, 8'ha5, 0},
        '{0, BASE_P1 - 10'h1, 0, 0, 0, 1},
        '{0, BASE_P2 + 10'h8, 0, 0, 0, 1},
        '{0, PCI_IDX + 10'h1, 0, 0, 0, 1},
        '{0, CFG_IDX, 0, 8'hff, 8'h10, 0},
        '{0, BASE_P1 + OFS_MSR, 0, 8'hf0, 8'h80, 0},
        '{0, BASE_P2 + OFS_MSR, 0, 8'hf0, 8'h20, 0},
        '{0, BASE_P3 + OFS_MSR, 0, 8'hf0, 8'h10, 0}};

    always #5 clk = ~clk;

    quad_serial_port_decode_irq #(.DIV_W(16)) quad_serial_port_decode_irq_i (
        .CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
        .WB_SEL_IN(4'h3), .WB_DAT_IN(wdat), .WB_DAT_OUT(dout),
        .WB_ACK_OUT(ack), .WB_ERR_OUT(err),
        .RXD_IN(rxd), .CTS_IN(cts), .DCD_IN(dcd), .DSR_IN(dsr), .RI_IN(ri),
        .TXD_OUT(txd), .RTS_OUT(rts), .DTR_OUT(dtr),
        .IRQ_LINE_OUT(irq), .IRQ_LINE_OE_OUT(oe), .INT_OUT(intr));

    serial_peer_model serial_peer_model_i (
        .clk_in(clk), .rxd_out(rxd), .cts_out(cts),
        .dcd_out(dcd), .dsr_out(dsr), .ri_out(ri));

    task automatic chk(input logic ok, input string s);
        comparisons++;
        if (!ok) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, s);
        end
    endtask

    // one classic cycle; request held until ack or err seen at an edge
    task automatic bus(input logic w, input logic [9:0] i, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {16'h0, d};
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && err !== 1'b1 && k < 50);
        q = dout;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 50) chk(1'b0, "no bus answer");
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard, well past two received frames plus register traffic
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk(oe === 4'h3 && txd === 4'hf && irq === 4'h0 && intr === 1'b0, "reset");
        $display("reset test done");
        foreach (rows[k]) begin
            bus(rows[k].w, rows[k].i, {8'h0, rows[k].d});
            if (!rows[k].w) begin
                chk(e === rows[k].e && (rows[k].e || (q[7:0] & rows[k].m) === rows[k].x),
                    "row");
            end
        end
        $display("table test done");
        // port one asks for IRQ12 but has only the low route bit
        bus(1'b1, CFG_IDX, 16'h0e30);
        settle();
        chk(oe === 4'hf, "routes");
        bus(1'b1, CFG_IDX, 16'h0e3c);
        bus(1'b0, BASE_P3, 16'h0);
        chk(e === 1'b1 && oe === 4'h3, "disabled port");
        bus(1'b1, PCI_IDX, 16'h0002);
        settle();
        chk(oe === 4'h1, "shared line driven");
        // shared line handed back before ports route to it
        bus(1'b1, PCI_IDX, 16'h0);
        bus(1'b1, CFG_IDX, {4'h0, CFG_RST});
        // firmware scan numbers only the ports that answer
        bus(1'b1, CFG_IDX, 16'h0115);
        n = 0;
        foreach (bases[p]) begin
            bus(1'b0, bases[p] + OFS_SCR, 16'h0);
            if (e === 1'b0) n++;
            desig[p] = (e === 1'b0) ? n : 0;
        end
        chk(desig[0] == 0 && desig[1] == 1 && desig[2] == 0 && desig[3] == 2, "numbering");
        bus(1'b1, CFG_IDX, {4'h0, CFG_RST});
        $display("routing test done");
        bus(1'b1, BASE_P1 + OFS_MCR, 16'h3);
        bus(1'b1, BASE_P3 + OFS_MCR, 16'h3);
        settle();
        chk(rts === 4'h5 && dtr === 2'h1, "modem outputs");
        bus(1'b1, BASE_P2 + OFS_DATA, 16'h55);
        n = 0;
        while (txd[1] !== 1'b0 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk(txd[1] === 1'b0, "tx start bit");
        // divisor one keeps the frame short
        bus(1'b1, BASE_P1 + OFS_LCR, 16'h83);
        bus(1'b1, BASE_P1 + OFS_DATA, 16'h1);
        bus(1'b1, BASE_P1 + OFS_DIVH, 16'h0);
        bus(1'b1, BASE_P1 + OFS_LCR, 16'h03);
        bus(1'b1, MSK_IDX, 16'h1);
        serial_peer_model_i.send(0, 8'h3c, BIT_CYC);
        n = 0;
        while (intr !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk(intr === 1'b1 && irq === 4'h2, "rx interrupt");
        bus(1'b0, BASE_P1 + OFS_DATA, 16'h0);
        chk(q[7:0] === 8'h3c, "rx byte");
        // five data bits: the upper frame bits stay high like idle
        bus(1'b1, BASE_P1 + OFS_LCR, 16'h00);
        serial_peer_model_i.send(0, 8'hf5, BIT_CYC);
        bus(1'b0, BASE_P1 + OFS_DATA, 16'h0);
        chk(q[7:0] === 8'h15, "five bit byte");
        bus(1'b1, CFG_IDX, 16'h011f);
        settle();
        chk(irq === 4'h0 && oe === 4'h0, "disabled port line");
        bus(1'b1, CFG_IDX, {4'h0, CFG_RST});
        bus(1'b1, STS_IDX, 16'h1);
        settle();
        chk(intr === 1'b0 && irq === 4'h0, "cleared");
        $display("serial test done");
        // mid-run reset brings back the reset values
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        settle();
        bus(1'b0, BASE_P1 + OFS_LCR, 16'h0);
        chk(q[7:0] === LCR_RST && oe === 4'h3 && intr === 1'b0, "mid reset");
        $display("mid reset test done");
        complete_run();
    end
endmodule
`default_nettype wire
